// *** src/adc_link_pkg.sv ***
// Shared constants for the converter serial port and its host controller
package adc_link_pkg;
	// ------------------------------------------------------------
	// Command frame layout
	// ------------------------------------------------------------
	localparam int         FRAME_BITS = 24;
	localparam int         OP_MSB     = 23;
	localparam int         OP_LSB     = 19;
	localparam int         ADDR_MSB   = 18;
	localparam int         ADDR_LSB   = 8;
	localparam int         DATA_MSB   = 7;
	localparam logic [4:0] OP_NOP     = 5'h00;
	localparam logic [4:0] OP_WRITE   = 5'h01;
	localparam logic [4:0] OP_READ    = 5'h02;
	localparam logic [4:0] OP_SET     = 5'h03;
	localparam logic [4:0] OP_CLEAR   = 5'h04;
	localparam int         SAMPLE_W   = 16;

	// ------------------------------------------------------------
	// Device register map
	// ------------------------------------------------------------
	localparam logic [10:0] ADDR_ACCESS    = 11'h000;
	localparam logic [10:0] ADDR_IN_PROTO  = 11'h008;
	localparam logic [10:0] ADDR_OUT_PROTO = 11'h00c;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [7:0]  UNLOCK_CODE    = 8'haa;
	localparam logic [7:0]  IN_PROTO_MASK  = 8'h03;
	localparam logic [7:0]  OUT_PROTO_MASK = 8'h13;
	localparam int          OUT_SEL_MSB    = 1;
	localparam int          LANE_WIDTH_BIT = 4;
	localparam logic [2:0]  LINK_IDLE      = 3'h4;

	// ------------------------------------------------------------
	// Host controller registers (Avalon-MM byte addresses)
	// ------------------------------------------------------------
	localparam int         HOST_ADDR_W   = 4;
	localparam logic [3:0] HREG_CMD      = 4'h0;
	localparam logic [3:0] HREG_CTRL     = 4'h4;
	localparam logic [3:0] HREG_STATUS   = 4'h8;
	localparam logic [3:0] HREG_RX       = 4'hc;
	localparam int         CTRL_WIDTH    = 2;
	localparam int         CTRL_CLK_LSB  = 8;
	localparam int         CTRL_CLK_MSB  = 13;
	localparam logic [5:0] DEF_CLOCKS    = 6'd24;
	localparam logic [5:0] MIN_CLOCKS    = 6'd16;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ    = 25;
	localparam int SCLK_PERIOD_NS = 640;
	localparam int HALF_CYCLES    = (SCLK_PERIOD_NS * SYS_CLK_MHZ + 1999) / 2000;
endpackage

// *** src/adc_link_if.sv ***
// Serial link between the host controller and the converter port
`timescale 1ns/1ps
interface adc_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic lane0;
	logic lane1_out;
	logic lane1_oe_n;
	logic ready;
	logic lane1_level;

	// Shared lane1 pin, weak pull-down when released
	assign lane1_level = lane1_oe_n ? 1'b0 : lane1_out;

	modport dev  (input cs_n, sclk, sdi, output lane0, lane1_out, lane1_oe_n, ready);
	modport host (output cs_n, sclk, sdi, input lane0, lane1_level, ready);
endinterface // adc_link_if

// *** src/adc_serial_port_dev.sv ***
// Converter end of the serial link: protocol modes, lanes and command frames
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module adc_serial_port_dev
	import adc_link_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	adc_link_if.dev                  link,
	input  wire logic [SAMPLE_W-1:0] sample_data,
	input  wire logic                seq_status,
	output logic      [1:0]          input_protocol_select,
	output logic      [1:0]          output_protocol_select,
	output logic                     output_lane_width,
	output logic                     sample_taken,
	output logic                     reg_cmd_done
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [2:0]            sync1_r;
	logic [2:0]            sync2_r;
	logic                  sclk_d_r;
	logic                  cs_d_r;
	logic [FRAME_BITS-1:0] rx_r;
	logic [5:0]            cnt_r;
	logic [FRAME_BITS-1:0] tx_r;
	logic                  first_r;
	logic                  lane0_r;
	logic                  lane1_r;
	logic                  lane1_oe_n_r;
	logic                  ready_r;
	logic [7:0]            access_r;
	logic [7:0]            input_protocol_reg_r;
	logic [7:0]            output_protocol_reg_r;
	logic [7:0]            rd_byte_r;
	logic                  read_pend_r;
	logic                  sample_taken_r;
	logic                  cmd_done_r;
	logic                  cs_s;
	logic                  sclk_s;
	logic                  sdi_s;
	logic                  sel;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  cpol;
	logic                  cpha;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  cap_edge;
	logic                  launch_edge;
	logic                  dual;
	logic                  retimed;
	logic                  frame_ok;
	logic                  unlocked;
	logic [4:0]            cmd_op;
	logic [10:0]           cmd_addr;
	logic [7:0]            cmd_data;
	logic [FRAME_BITS-1:0] tx_load;
	logic [FRAME_BITS-1:0] tx_next;

	// Register update for write, set and clear
	function automatic logic [7:0] apply_op(input logic [4:0] op, input logic [7:0] old, input logic [7:0] d);
		case (op)
			OP_WRITE: apply_op = d;
			OP_SET:   apply_op = old | d;
			OP_CLEAR: apply_op = old & ~d;
			default:  apply_op = old;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	// Two flops on cs_n, sclk, sdi
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= LINK_IDLE;
			sync2_r <= LINK_IDLE;
		end else begin
			sync1_r <= {link.cs_n, link.sclk, link.sdi};
			sync2_r <= sync1_r;
		end
	end

	// Previous synchronised levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_s;
		end
	end

	// Mode decode and edges
	assign cs_s        = sync2_r[2];
	assign sclk_s      = sync2_r[1];
	assign sdi_s       = sync2_r[0];
	assign sel         = ~cs_s;
	assign cs_fall     = ~cs_s & cs_d_r;
	assign cs_rise     = cs_s & ~cs_d_r;
	assign cpol        = input_protocol_reg_r[1];
	assign cpha        = input_protocol_reg_r[0];
	assign sclk_rise   = sclk_s & ~sclk_d_r;
	assign sclk_fall   = ~sclk_s & sclk_d_r;
	assign cap_edge    = sel & ((cpol ^ cpha) ? sclk_fall : sclk_rise);
	assign launch_edge = sel & ((cpol ^ cpha) ? sclk_rise : sclk_fall);
	assign dual        = output_protocol_reg_r[LANE_WIDTH_BIT];
	assign retimed     = |output_protocol_reg_r[OUT_SEL_MSB:0];

	// ------------------------------------------------------------
	// Input shifter
	// ------------------------------------------------------------
	// Capture sdi on capture edges only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_r  <= '0;
			cnt_r <= '0;
		end else if (cs_fall) begin
			rx_r  <= '0;
			cnt_r <= '0;
		end else if (cap_edge) begin
			rx_r <= {rx_r[FRAME_BITS-2:0], sdi_s};
			if (cnt_r != DEF_CLOCKS)
				cnt_r <= cnt_r + 6'h01;
		end
	end

	// Frame fields
	assign cmd_op   = rx_r[OP_MSB:OP_LSB];
	assign cmd_addr = rx_r[ADDR_MSB:ADDR_LSB];
	assign cmd_data = rx_r[DATA_MSB:0];
	assign frame_ok = cs_rise & (cnt_r == DEF_CLOCKS);
	assign unlocked = (access_r == UNLOCK_CODE);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Access register, always writable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			access_r <= REG_RESET;
		else if (frame_ok && cmd_addr == ADDR_ACCESS)
			access_r <= apply_op(cmd_op, access_r, cmd_data);
	end

	// Protocol registers, gated by unlock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_protocol_reg_r  <= REG_RESET;
			output_protocol_reg_r <= REG_RESET;
		end else if (frame_ok && unlocked) begin
			if (cmd_addr == ADDR_IN_PROTO)
				input_protocol_reg_r <= apply_op(cmd_op, input_protocol_reg_r, cmd_data) & IN_PROTO_MASK;
			if (cmd_addr == ADDR_OUT_PROTO)
				output_protocol_reg_r <= apply_op(cmd_op, output_protocol_reg_r, cmd_data) & OUT_PROTO_MASK;
		end
	end

	// Read command latches byte for next frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte_r   <= REG_RESET;
			read_pend_r <= 1'b0;
		end else if (frame_ok && cmd_op == OP_READ) begin
			read_pend_r <= 1'b1;
			case (cmd_addr)
				ADDR_ACCESS:    rd_byte_r <= access_r;
				ADDR_IN_PROTO:  rd_byte_r <= input_protocol_reg_r;
				ADDR_OUT_PROTO: rd_byte_r <= output_protocol_reg_r;
				default:        rd_byte_r <= REG_RESET;
			endcase
		end else if (cs_fall) begin
			read_pend_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output shifter and lanes
	// ------------------------------------------------------------
	assign tx_load = read_pend_r ? {rd_byte_r, {SAMPLE_W{1'b0}}} : {sample_data, 8'h00};
	assign tx_next = dual ? {tx_r[FRAME_BITS-3:0], 2'b00} : {tx_r[FRAME_BITS-2:0], 1'b0};

	// Launch bits at select fall or launch edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_r    <= '0;
			first_r <= 1'b0;
			lane0_r <= 1'b0;
			lane1_r <= 1'b0;
		end else if (cs_fall) begin
			tx_r    <= tx_load;
			first_r <= cpha;
			if (!cpha) begin
				lane0_r <= dual ? tx_load[FRAME_BITS-2] : tx_load[FRAME_BITS-1];
				lane1_r <= dual ? tx_load[FRAME_BITS-1] : 1'b1;
			end
		end else if (launch_edge) begin
			if (first_r) begin
				first_r <= 1'b0;
				lane0_r <= dual ? tx_r[FRAME_BITS-2] : tx_r[FRAME_BITS-1];
				lane1_r <= dual ? tx_r[FRAME_BITS-1] : 1'b1;
			end else begin
				tx_r    <= tx_next;
				lane0_r <= dual ? tx_next[FRAME_BITS-2] : tx_next[FRAME_BITS-1];
				lane1_r <= dual ? tx_next[FRAME_BITS-1] : 1'b1;
			end
		end else if (!dual)
			lane1_r <= 1'b1;
	end

	// Lane1 pin: data lane or sequence status
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			lane1_oe_n_r <= 1'b1;
		else
			lane1_oe_n_r <= ~(dual | seq_status);
	end

	// Ready: low in output mode 0, clock in re-timed modes 1 to 3
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ready_r <= 1'b0;
		else if (!retimed || !sel)
			ready_r <= 1'b0;
		else if (launch_edge)
			ready_r <= 1'b1;
		else if (cap_edge)
			ready_r <= 1'b0;
	end

	// User-side strobes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_taken_r <= 1'b0;
			cmd_done_r     <= 1'b0;
		end else begin
			sample_taken_r <= cs_fall & ~read_pend_r;
			cmd_done_r     <= frame_ok;
		end
	end

	assign link.lane0             = lane0_r;
	assign link.lane1_out         = lane1_r;
	assign link.lane1_oe_n        = lane1_oe_n_r;
	assign link.ready             = ready_r;
	assign input_protocol_select  = input_protocol_reg_r[1:0];
	assign output_protocol_select = output_protocol_reg_r[OUT_SEL_MSB:0];
	assign output_lane_width      = output_protocol_reg_r[LANE_WIDTH_BIT];
	assign sample_taken           = sample_taken_r;
	assign reg_cmd_done           = cmd_done_r;
endmodule // adc_serial_port_dev

// *** src/adc_serial_host.sv ***
// Host end of the serial link with an Avalon-MM command port
`timescale 1ns/1ps
module adc_serial_host
	import adc_link_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
)(
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	adc_link_if.host                    link,
	input  wire logic [HOST_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest
);
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_SETUP = 3'b001,
		H_CLOCK = 3'b010,
		H_HOLD  = 3'b011,
		H_GAP   = 3'b100
	} hstate_t;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hstate_t               state_r;
	logic [7:0]            div_r;
	logic [6:0]            edge_r;
	logic [FRAME_BITS-1:0] tx_r;
	logic [FRAME_BITS-1:0] rx_r;
	logic [FRAME_BITS-1:0] rx_word_r;
	logic [FRAME_BITS-1:0] cmd_r;
	logic                  start_r;
	logic [1:0]            mode_r;
	logic                  width_r;
	logic [5:0]            clocks_r;
	logic [1:0]            fmode_r;
	logic                  fwidth_r;
	logic [6:0]            last_edge_r;
	logic                  cs_n_r;
	logic                  sclk_r;
	logic                  sdi_r;
	logic [2:0]            sync1_r;
	logic [2:0]            sync2_r;
	logic [31:0]           rdata_r;
	logic                  wait_r;
	logic                  busy;
	logic                  tick;
	logic                  cpha;
	logic                  odd;
	logic                  hold_off;
	logic                  acc;
	logic [5:0]            clk_req;

	assign busy     = (state_r != H_IDLE) | start_r;
	assign tick     = (div_r == 8'h00);
	assign cpha     = fmode_r[0];
	assign odd      = edge_r[0];
	assign hold_off = avs_write & (avs_address == HREG_CMD) & busy;
	assign acc      = (avs_read | avs_write) & wait_r & ~hold_off;
	assign clk_req  = avs_writedata[CTRL_CLK_MSB:CTRL_CLK_LSB];

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	// Wait low for one cycle per access; command held off while busy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r  <= 1'b1;
			rdata_r <= '0;
		end else begin
			wait_r <= ~acc;
			if (acc && avs_read) begin
				case (avs_address)
					HREG_CMD:    rdata_r <= {8'h00, cmd_r};
					HREG_CTRL:   rdata_r <= {18'h0, clocks_r, 5'h00, width_r, mode_r};
					HREG_STATUS: rdata_r <= {30'h0, sync2_r[2], busy};
					HREG_RX:     rdata_r <= {8'h00, rx_word_r};
					default:     rdata_r <= '0;
				endcase
			end
		end
	end

	// Register writes at the accepting edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r    <= '0;
			start_r  <= 1'b0;
			mode_r   <= 2'b00;
			width_r  <= 1'b0;
			clocks_r <= DEF_CLOCKS;
		end else begin
			start_r <= 1'b0;
			if (avs_write && !wait_r) begin
				if (avs_address == HREG_CMD) begin
					cmd_r   <= avs_writedata[FRAME_BITS-1:0];
					start_r <= 1'b1;
				end
				if (avs_address == HREG_CTRL) begin
					mode_r   <= avs_writedata[1:0];
					width_r  <= avs_writedata[CTRL_WIDTH];
					clocks_r <= (clk_req < MIN_CLOCKS) ? MIN_CLOCKS : clk_req;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Input synchronisers: ready, lane1, lane0
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {link.ready, link.lane1_level, link.lane0};
			sync2_r <= sync1_r;
		end
	end

	// ------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= H_IDLE;
			div_r       <= '0;
			edge_r      <= '0;
			tx_r        <= '0;
			rx_r        <= '0;
			rx_word_r   <= '0;
			fmode_r     <= 2'b00;
			fwidth_r    <= 1'b0;
			last_edge_r <= '0;
			cs_n_r      <= 1'b1;
			sclk_r      <= 1'b0;
			sdi_r       <= 1'b0;
		end else begin
			div_r <= tick ? 8'(HALF - 1) : div_r - 8'h01;
			case (state_r)
				H_IDLE: begin
					sclk_r <= mode_r[1];
					if (start_r) begin
						// Mode latched per frame; software orders mode changes
						fmode_r     <= mode_r;
						fwidth_r    <= width_r;
						last_edge_r <= {clocks_r, 1'b0} - 7'h01;
						tx_r        <= cmd_r;
						rx_r        <= '0;
						edge_r      <= '0;
						cs_n_r      <= 1'b0;
						sdi_r       <= mode_r[0] ? 1'b0 : cmd_r[FRAME_BITS-1];
						div_r       <= 8'(HALF - 1);
						state_r     <= H_SETUP;
					end
				end
				H_SETUP: if (tick) begin
					state_r <= H_CLOCK;
				end
				H_CLOCK: if (tick) begin
					sclk_r <= ~sclk_r;
					edge_r <= edge_r + 7'h01;
					if (cpha ? !odd : odd) begin
						sdi_r <= cpha ? tx_r[FRAME_BITS-1] : tx_r[FRAME_BITS-2];
						tx_r  <= {tx_r[FRAME_BITS-2:0], 1'b0};
					end else begin
						rx_r <= fwidth_r ? {rx_r[FRAME_BITS-3:0], sync2_r[1], sync2_r[0]}
						                 : {rx_r[FRAME_BITS-2:0], sync2_r[0]};
					end
					if (edge_r == last_edge_r)
						state_r <= H_HOLD;
				end
				H_HOLD: if (tick) begin
					cs_n_r    <= 1'b1;
					rx_word_r <= rx_r;
					state_r   <= H_GAP;
				end
				H_GAP: if (tick) begin
					state_r <= H_IDLE;
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	assign link.cs_n       = cs_n_r;
	assign link.sclk       = sclk_r;
	assign link.sdi        = sdi_r;
	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
endmodule // adc_serial_host

// *** bench/adc_link_props.sv ***
// Link checker for the serial interface between host and converter
`timescale 1ns/1ps
module adc_link_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic lane0,
	input wire logic ready
);
	logic       sclk_d;
	logic       cs_d;
	logic [6:0] edges_r;
	logic       evt;

	// Pin edge history and clock edge count per frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d  <= 1'b0;
			cs_d    <= 1'b1;
			edges_r <= 7'h00;
		end else begin
			sclk_d  <= sclk;
			cs_d    <= cs_n;
			edges_r <= cs_n ? 7'h00 : edges_r + 7'(sclk != sclk_d);
		end
	end
	assign evt = (sclk != sclk_d) || (cs_n != cs_d);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// --------------------------------------------------------
	// Frame steps
	// --------------------------------------------------------
	sequence setup_s;
		##1 $stable(sclk)[*8] ##1 $stable(sclk)[*7] ##1 $changed(sclk);
	endsequence
	sequence gap_s;
		cs_n[*8];
	endsequence

	setup_time_a: assert property ($fell(cs_n) |-> setup_s)
		else $error("first clock edge not sixteen cycles after select");
	select_gap_a: assert property ($rose(cs_n) |-> gap_s)
		else $error("select gap too short");
	half_period_a: assert property (!cs_n && $changed(sclk) |-> ##1 $stable(sclk)[*7])
		else $error("serial clock half period wrong");
	edge_count_a: assert property ($rose(cs_n) |-> edges_r == 7'd48 || edges_r == 7'd32)
		else $error("frame clock count wrong");
	frame_len_a: assert property ($fell(cs_n) |-> ##[272:400] $rose(cs_n))
		else $error("frame length out of range");
	sdi_launch_a: assert property (!cs_n && $changed(sdi) |-> $changed(sclk) || $fell(cs_n))
		else $error("input line moved off a clock edge");
	lane_timing_a: assert property ($changed(lane0) |-> $past(evt, 3))
		else $error("lane0 moved without a pin edge");
	ready_timing_a: assert property (!cs_n && $changed(ready) |-> $past(evt, 3))
		else $error("ready moved without a pin edge");
endmodule // adc_link_props

// *** bench/tb_adc_serial_read_and_register_port.sv ***
// Testbench joining host controller and converter port
`timescale 1ns/1ps
module tb_adc_serial_read_and_register_port;
	import adc_link_pkg::*;
	logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, seq_status, lane_w, rdy_d, st_w, cd_w;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] sample;
	logic [1:0]  in_sel, out_sel;
	logic [23:0] rx;
	logic [7:0]  b;
	int          err_total, total_checks, cyc, rises, r0, n_st, n_cd, c0, s0;

	adc_link_if link_i ();
	adc_serial_port_dev adc_serial_port_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_i),
		.sample_data(sample), .seq_status(seq_status), .input_protocol_select(in_sel),
		.output_protocol_select(out_sel), .output_lane_width(lane_w), .sample_taken(st_w), .reg_cmd_done(cd_w));
	adc_serial_host #(.HALF(8)) adc_serial_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_i),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	adc_link_props adc_link_props_i (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link_i.cs_n), .sclk(link_i.sclk),
		.sdi(link_i.sdi), .lane0(link_i.lane0), .ready(link_i.ready));

	// Clock, timeout, ready edges and strobe counts
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		rdy_d <= link_i.ready;
		if (link_i.ready === 1'b1 && rdy_d === 1'b0) rises <= rises + 1;
		if (st_w === 1'b1) n_st <= n_st + 1;
		if (cd_w === 1'b1) n_cd <= n_cd + 1;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic ctrl(input logic [1:0] m, input logic dual, input logic [5:0] nclk);
		logic [31:0] q;
		av(1'b1, HREG_CTRL, {18'h0, nclk, 5'h0, dual, m}, q);
	endtask
	task automatic frame(input logic [4:0] op, input logic [10:0] a, input logic [7:0] d);
		logic [31:0] q;
		av(1'b1, HREG_CMD, {8'h00, op, a, d}, q);
		repeat (4) @(posedge sys_clk);
		q = 32'h1;
		while (q[0] !== 1'b0) begin
			av(1'b0, HREG_STATUS, 32'h0, q);
		end
		av(1'b0, HREG_RX, 32'h0, q);
		rx = q[23:0];
	endtask
	task automatic rd_reg(input logic [10:0] a);
		frame(OP_READ, a, 8'h00);
		frame(OP_NOP, 11'h000, 8'h00);
		b = rx[23:16];
	endtask

	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		chk(32'(in_sel), 32'h0);
		av(1'b0, HREG_CTRL, 32'h0, q);
		chk(q, 32'h1800);
		av(1'b0, 4'h2, 32'h0, q);
		chk(q, 32'h0);
		seq_status <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(32'(link_i.lane1_level), 32'h1);
		seq_status <= 1'b0;
		$display("reset test done");
	endtask
	task automatic t_lock();
		frame(OP_WRITE, ADDR_IN_PROTO, 8'h01);
		chk(32'(in_sel), 32'h0);
		frame(OP_WRITE, ADDR_ACCESS, UNLOCK_CODE);
		c0 = n_cd;
		s0 = n_st;
		rd_reg(ADDR_ACCESS);
		chk(32'(b), 32'(UNLOCK_CODE));
		chk(32'(n_cd - c0), 32'h2);
		chk(32'(n_st - s0), 32'h1);
		$display("lock test done");
	endtask
	task automatic t_ignore();
		logic [4:0] ops [3];
		ops = '{OP_NOP, 5'h05, 5'h1f};
		foreach (ops[i]) begin
			frame(ops[i], ADDR_ACCESS, 8'h55);
			rd_reg(ADDR_ACCESS);
			chk(32'(b), 32'(UNLOCK_CODE));
		end
		ctrl(2'h0, 1'b0, 6'd16);
		c0 = n_cd;
		frame(OP_WRITE, ADDR_ACCESS, 8'h00);
		chk(32'(n_cd - c0), 32'h0);
		ctrl(2'h0, 1'b0, DEF_CLOCKS);
		rd_reg(ADDR_ACCESS);
		chk(32'(b), 32'(UNLOCK_CODE));
		$display("ignore test done");
	endtask
	task automatic t_modes();
		logic [1:0] ms [4];
		ms = '{2'h1, 2'h2, 2'h3, 2'h0};
		foreach (ms[i]) begin
			frame(OP_WRITE, ADDR_IN_PROTO, {6'h0, ms[i]});
			ctrl(ms[i], 1'b0, DEF_CLOCKS);
			chk(32'(in_sel), 32'(ms[i]));
			rd_reg(ADDR_ACCESS);
			chk(32'(b), 32'(UNLOCK_CODE));
		end
		$display("mode test done");
	endtask
	task automatic t_lanes();
		sample <= 16'ha5c3;
		r0 = rises;
		ctrl(2'h0, 1'b0, MIN_CLOCKS);
		frame(OP_NOP, 11'h000, 8'h00);
		chk(32'(rx[15:0]), 32'ha5c3);
		chk(32'(rises - r0), 32'h0);
		ctrl(2'h0, 1'b0, DEF_CLOCKS);
		frame(OP_SET, ADDR_OUT_PROTO, 8'h10);
		chk(32'(lane_w), 32'h1);
		ctrl(2'h0, 1'b1, MIN_CLOCKS);
		frame(OP_NOP, 11'h000, 8'h00);
		chk(32'(rx[23:16]), 32'hc3);
		ctrl(2'h0, 1'b1, DEF_CLOCKS);
		frame(OP_CLEAR, ADDR_OUT_PROTO, 8'h10);
		chk(32'(lane_w), 32'h0);
		ctrl(2'h0, 1'b0, DEF_CLOCKS);
		$display("lane test done");
	endtask
	task automatic t_retime();
		frame(OP_SET, ADDR_OUT_PROTO, 8'h01);
		chk(32'(out_sel), 32'h1);
		r0 = rises;
		frame(OP_NOP, 11'h000, 8'h00);
		chk(32'(rises - r0), 32'(DEF_CLOCKS));
		chk(32'(rx), 32'ha5c300);
		frame(OP_CLEAR, ADDR_OUT_PROTO, 8'h01);
		chk(32'(out_sel), 32'h0);
		$display("retime test done");
	endtask

	// Main sequence
	initial begin
		{rst_n, avs_read, avs_write, seq_status, rdy_d} = '0;
		avs_address = '0;
		avs_writedata = '0;
		sample = '0;
		{err_total, total_checks, cyc, rises, n_st, n_cd} = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		t_reset();
		t_lock();
		t_ignore();
		t_modes();
		t_lanes();
		t_retime();
		close_out();
	end
endmodule // tb_adc_serial_read_and_register_port
